/* File: src/eps_pkg.sv */
/*
 * Shared constants, state codes and helpers for the display power
 * supervisor. Assumes a 200 MHz system clock.
 */
`default_nettype none
package eps_pkg;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_SLEEP     = 4'h0,
        ST_STANDBY   = 4'h1,
        ST_UP_NEG    = 4'h2,
        ST_UP_POS    = 4'h3,
        ST_UP_RAILS  = 4'h4,
        ST_ACTIVE    = 4'h5,
        ST_DOWN      = 4'h6,
        ST_DISCHARGE = 4'h7
    } eps_state_type;

    // Timing: times in ms, counts derived from the clock rate in kHz
    localparam int CLK_KHZ       = 200000;
    localparam int DISCHARGE_MS  = 100;
    localparam int BOOST_TMO_MS  = 50;
    localparam int DISCHARGE_CYC = DISCHARGE_MS * CLK_KHZ;
    localparam int BOOST_TMO_CYC = BOOST_TMO_MS * CLK_KHZ;
    localparam int TMR_W         = 25;

    // Rail level scale: nominal output reads as RAIL_NOMINAL
    localparam int                LVL_W        = 10;
    localparam logic [LVL_W-1:0]  RAIL_NOMINAL = 10'h3e8;
    localparam logic [13:0]       PG_NUM       = 14'h009;
    localparam logic [13:0]       PG_DEN       = 14'h00a;

    // Monitored rails, bit positions
    localparam int RAIL_PCP  = 0;
    localparam int RAIL_NCP  = 1;
    localparam int RAIL_PSRC = 2;
    localparam int RAIL_NSRC = 3;
    localparam int NRAIL     = 4;

    // Event flags, bit positions
    localparam int FLG_HOT  = 0;
    localparam int FLG_COLD = 1;
    localparam int FLG_CHG  = 2;
    localparam int FLG_UVN  = 3;
    localparam int FLG_UVP  = 4;
    localparam int NFLG     = 5;

    // Temperature and configuration reset values
    localparam int          TEMP_W    = 8;
    localparam logic [7:0]  HOT_RST   = 8'h8c;
    localparam logic [7:0]  COOL_RST  = 8'h82;
    localparam logic [7:0]  COLD_RST  = 8'h64;
    localparam logic [7:0]  DELTA_RST = 8'h08;
    localparam logic [7:0]  BASE_RST  = 8'h78;
    localparam logic [2:0]  VSET_RST  = 3'h3;
    localparam logic [3:0]  RAILS_RST = 4'h0;

    // In regulation once level reaches nine tenths of nominal
    function automatic logic eps_in_reg(input logic [LVL_W-1:0] lvl);
        eps_in_reg = (({4'h0, lvl} * PG_DEN) >= ({4'h0, RAIL_NOMINAL} * PG_NUM));
    endfunction

endpackage
`default_nettype wire

/* File: src/eps_power_supervisor.sv */
/*
 * Display power supervisor: wake and power-up sequencing, discharge
 * delay, power-good aggregation and thermistor conversion events.
 * Assumes rail levels, faults and boost good come from logic on the
 * system clock; the converter runs on its own clock i_clk_adc.
 */
// Behaviour
// - A rail counts as regulated once it reaches 90% of nominal.
// - Power-good is pulled low if any of four rails is low or faulted.
// - Power-good stays low while any monitored rail is not enabled.
// - Power-good is released only when all four rails are regulated.
// - Conversions start only on host request, never by themselves.
// - Latest conversion result is held, replacing the previous one.
// - Events on crossing above hot threshold, and on every result below cold threshold.
// - Event when result differs from baseline by more than delta.
// - Hot threshold code 0x8c stands for 50 degrees.
// - Cool threshold code 0x82 stands for 45; hot clears below it.
// - Host enables rails and sets thermal and event configuration.
// - Host may change the regulator voltage setting.
// - Sleep from standby is immediate; from power-down only after a full 100 ms discharge delay.
// - Rising power-up request pin starts the power-up sequence.
// - Wake pin low while up runs power-down, discharge, then sleep.
// - Wake rising with request high goes straight to power-up.
// - Boost not good within 50 ms sets flag, interrupt, standby.
// - Negative boost stays on through the discharge delay only.
// - Sleep resets configuration and ignores configuration writes.
`timescale 1ns/10ps
`default_nettype none
module eps_power_supervisor
    import eps_pkg::*;
#(
    parameter int DISCHARGE_CYCLES = DISCHARGE_CYC,
    parameter int BOOST_TMO_CYCLES = BOOST_TMO_CYC
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_sys_rst,
    input  wire logic              i_clk_adc,
    input  wire logic              i_wake_request_pin,
    input  wire logic              i_rail_sequence_request_pin,
    input  wire logic              i_cfg_wr,
    input  wire logic              i_cfg_active,
    input  wire logic [NRAIL-1:0]  i_cfg_rail_en,
    input  wire logic [2:0]        i_cfg_ldo_vset,
    input  wire logic [TEMP_W-1:0] i_cfg_hot_thr,
    input  wire logic [TEMP_W-1:0] i_cfg_cool_thr,
    input  wire logic [TEMP_W-1:0] i_cfg_cold_thr,
    input  wire logic [TEMP_W-1:0] i_cfg_delta_thr,
    input  wire logic [TEMP_W-1:0] i_cfg_baseline,
    input  wire logic              i_temp_req,
    input  wire logic [NFLG-1:0]   i_flag_clr,
    input  wire logic              i_neg_boost_good,
    input  wire logic              i_pos_boost_good,
    input  wire logic [LVL_W-1:0]  i_lvl_pcp,
    input  wire logic [LVL_W-1:0]  i_lvl_ncp,
    input  wire logic [LVL_W-1:0]  i_lvl_psrc,
    input  wire logic [LVL_W-1:0]  i_lvl_nsrc,
    input  wire logic [NRAIL-1:0]  i_rail_fault,
    input  wire logic              i_adc_done,
    input  wire logic [TEMP_W-1:0] i_adc_data,
    output logic                   o_negative_boost_converter_en,
    output logic                   o_positive_boost_en,
    output logic [NRAIL-1:0]       o_rail_en,
    output logic [2:0]             o_ldo_vset,
    output logic                   o_rails_good_output_o,
    output logic                   o_rails_good_output_oe,
    output logic                   o_interrupt_output_low_n,
    output logic [NFLG-1:0]        o_flags,
    output logic [TEMP_W-1:0]      o_temperature_result,
    output logic                   o_temp_busy,
    output logic                   o_adc_start,
    output logic                   o_sleep
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    eps_state_type     state_reg, state_next;
    logic              wake_s1_reg, wake_s2_reg;
    logic              req_s1_reg, req_s2_reg, req_s3_reg;
    logic              req_rise, req_fall, down_req, active_req, cfg_ok;
    logic [TMR_W-1:0]  timer_reg;
    logic              tmo, dis_done;
    logic [NRAIL-1:0]  rail_cfg_reg, rail_en_reg, rail_ok;
    logic [2:0]        vset_reg;
    logic [TEMP_W-1:0] hot_thr_reg, cool_thr_reg, cold_thr_reg;
    logic [TEMP_W-1:0] delta_thr_reg, base_reg, result_reg, diff;
    logic              pg_oe_reg, hot_st_reg, busy_reg, req_tgl_reg;
    logic              neg_en_reg, pos_en_reg, int_n_reg, sleep_reg;
    logic [NFLG-1:0]   flags_reg, flag_set;
    logic              dsync1_reg, dsync2_reg, dsync3_reg, done_ev;
    logic              lrst_s1_reg, lrst_s2_reg;
    logic              lreq_s1_reg, lreq_s2_reg, lreq_s3_reg;
    logic              start_reg, lwait_reg, done_tgl_reg;
    logic [TEMP_W-1:0] adc_data_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; request edges come from the settled stages
    always_ff @(posedge i_clk_sys) begin
        wake_s1_reg <= i_wake_request_pin;
        wake_s2_reg <= wake_s1_reg;
        req_s1_reg  <= i_rail_sequence_request_pin;
        req_s2_reg  <= req_s1_reg;
        req_s3_reg  <= req_s2_reg;
    end

    assign req_rise   = req_s2_reg & ~req_s3_reg;
    assign req_fall   = ~req_s2_reg & req_s3_reg;
    assign down_req   = ~wake_s2_reg | req_fall;
    assign cfg_ok     = (state_reg != ST_SLEEP);
    assign active_req = i_cfg_wr & i_cfg_active & cfg_ok;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_reg <= ST_SLEEP;
        end else begin
            state_reg <= state_next;
        end
    end

    // Boost timeouts fall back to standby, never to sleep
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_SLEEP: begin
                if (wake_s2_reg) begin
                    state_next = req_s2_reg ? ST_UP_NEG : ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (!wake_s2_reg) begin
                    state_next = ST_SLEEP;
                end else if (req_rise || active_req) begin
                    state_next = ST_UP_NEG;
                end
            end
            ST_UP_NEG: begin
                if (down_req) begin
                    state_next = ST_DOWN;
                end else if (i_neg_boost_good) begin
                    state_next = ST_UP_POS;
                end else if (tmo) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_UP_POS: begin
                if (down_req) begin
                    state_next = ST_DOWN;
                end else if (i_pos_boost_good) begin
                    state_next = ST_UP_RAILS;
                end else if (tmo) begin
                    state_next = ST_STANDBY;
                end
            end
            ST_UP_RAILS: begin
                state_next = down_req ? ST_DOWN : ST_ACTIVE;
            end
            ST_ACTIVE: begin
                if (down_req) begin
                    state_next = ST_DOWN;
                end
            end
            ST_DOWN: begin
                state_next = ST_DISCHARGE;
            end
            ST_DISCHARGE: begin
                if (dis_done) begin
                    state_next = wake_s2_reg ? ST_STANDBY : ST_SLEEP;
                end
            end
            default: begin
                state_next = ST_SLEEP;
            end
        endcase
    end

    // Sleep indication registered so the pin comes straight from a flop
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            sleep_reg <= 1'b1;
        end else begin
            sleep_reg <= (state_next == ST_SLEEP);
        end
    end

    // One timer serves both the boost timeout and the discharge delay
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || state_next != state_reg) begin
            timer_reg <= '0;
        end else if (!dis_done) begin
            timer_reg <= timer_reg + TMR_W'(1);
        end
    end

    assign tmo      = (timer_reg == TMR_W'(BOOST_TMO_CYCLES - 1));
    assign dis_done = (state_reg == ST_DISCHARGE) &&
                      (timer_reg == TMR_W'(DISCHARGE_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////
    // Converter and rail enables follow the next state
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            neg_en_reg  <= 1'b0;
            pos_en_reg  <= 1'b0;
            rail_en_reg <= '0;
        end else begin
            neg_en_reg  <= (state_next >= ST_UP_NEG);
            pos_en_reg  <= (state_next >= ST_UP_POS) &&
                           (state_next <= ST_ACTIVE);
            rail_en_reg <= (state_next == ST_ACTIVE) ? rail_cfg_reg : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Host configuration; wiped in sleep, writes ignored there
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst || !cfg_ok) begin
            rail_cfg_reg  <= RAILS_RST;
            vset_reg      <= VSET_RST;
            hot_thr_reg   <= HOT_RST;
            cool_thr_reg  <= COOL_RST;
            cold_thr_reg  <= COLD_RST;
            delta_thr_reg <= DELTA_RST;
            base_reg      <= BASE_RST;
        end else if (i_cfg_wr) begin
            rail_cfg_reg  <= i_cfg_rail_en;
            vset_reg      <= i_cfg_ldo_vset;
            hot_thr_reg   <= i_cfg_hot_thr;
            cool_thr_reg  <= i_cfg_cool_thr;
            cold_thr_reg  <= i_cfg_cold_thr;
            delta_thr_reg <= i_cfg_delta_thr;
            base_reg      <= i_cfg_baseline;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power-good: every rail enabled, regulated and fault free
    assign rail_ok[RAIL_PCP]  = eps_in_reg(i_lvl_pcp);
    assign rail_ok[RAIL_NCP]  = eps_in_reg(i_lvl_ncp);
    assign rail_ok[RAIL_PSRC] = eps_in_reg(i_lvl_psrc);
    assign rail_ok[RAIL_NSRC] = eps_in_reg(i_lvl_nsrc);

    // Pin is pulled low by enabling the driver; level itself stays 0
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pg_oe_reg <= 1'b1;
        end else begin
            pg_oe_reg <= ~&(rail_ok & rail_en_reg & ~i_rail_fault);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion request: host only, one at a time, toggle crossing
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            req_tgl_reg <= 1'b0;
            busy_reg    <= 1'b0;
        end else if (i_temp_req && !busy_reg && cfg_ok) begin
            req_tgl_reg <= ~req_tgl_reg;
            busy_reg    <= 1'b1;
        end else if (done_ev) begin
            busy_reg    <= 1'b0;
        end
    end

    // Completion toggle from the converter domain
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            dsync1_reg <= 1'b0;
            dsync2_reg <= 1'b0;
            dsync3_reg <= 1'b0;
        end else begin
            dsync1_reg <= done_tgl_reg;
            dsync2_reg <= dsync1_reg;
            dsync3_reg <= dsync2_reg;
        end
    end

    // Result word is held still in its domain until the next request
    assign done_ev = dsync2_reg ^ dsync3_reg;
    assign diff    = (adc_data_reg >= base_reg) ? adc_data_reg - base_reg
                                                : base_reg - adc_data_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            result_reg <= '0;
            hot_st_reg <= 1'b0;
        end else if (done_ev) begin
            result_reg <= adc_data_reg;
            if (adc_data_reg > hot_thr_reg) begin
                hot_st_reg <= 1'b1;
            end else if (adc_data_reg < cool_thr_reg) begin
                hot_st_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky event flags; a set in the clear cycle wins
    always_comb begin
        flag_set           = '0;
        flag_set[FLG_HOT]  = done_ev && !hot_st_reg &&
                             (adc_data_reg > hot_thr_reg);
        flag_set[FLG_COLD] = done_ev && (adc_data_reg < cold_thr_reg);
        flag_set[FLG_CHG]  = done_ev && (diff > delta_thr_reg);
        flag_set[FLG_UVN]  = (state_reg == ST_UP_NEG) && tmo &&
                             (state_next == ST_STANDBY);
        flag_set[FLG_UVP]  = (state_reg == ST_UP_POS) && tmo &&
                             (state_next == ST_STANDBY);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            flags_reg <= '0;
            int_n_reg <= 1'b1;
        end else begin
            flags_reg <= flag_set | (flags_reg & ~i_flag_clr);
            int_n_reg <= ~|flags_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter domain: reset, request sync, start pulse, capture
    always_ff @(posedge i_clk_adc) begin
        lrst_s1_reg <= i_sys_rst;
        lrst_s2_reg <= lrst_s1_reg;
    end

    always_ff @(posedge i_clk_adc) begin
        if (lrst_s2_reg) begin
            lreq_s1_reg  <= 1'b0;
            lreq_s2_reg  <= 1'b0;
            lreq_s3_reg  <= 1'b0;
            start_reg    <= 1'b0;
            lwait_reg    <= 1'b0;
            done_tgl_reg <= 1'b0;
            adc_data_reg <= '0;
        end else begin
            lreq_s1_reg <= req_tgl_reg;
            lreq_s2_reg <= lreq_s1_reg;
            lreq_s3_reg <= lreq_s2_reg;
            start_reg   <= lreq_s2_reg ^ lreq_s3_reg;
            if (start_reg) begin
                lwait_reg <= 1'b1;
            end else if (lwait_reg && i_adc_done) begin
                lwait_reg    <= 1'b0;
                adc_data_reg <= i_adc_data;
                done_tgl_reg <= ~done_tgl_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_negative_boost_converter_en = neg_en_reg;
    assign o_positive_boost_en           = pos_en_reg;
    assign o_rail_en                     = rail_en_reg;
    assign o_ldo_vset                    = vset_reg;
    assign o_rails_good_output_o         = 1'b0;
    assign o_rails_good_output_oe        = pg_oe_reg;
    assign o_interrupt_output_low_n      = int_n_reg;
    assign o_flags                       = flags_reg;
    assign o_temperature_result          = result_reg;
    assign o_temp_busy                   = busy_reg;
    assign o_adc_start                   = start_reg;
    assign o_sleep                       = sleep_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the system clock
    default clocking cb_sys @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    AST_PG_LEVEL: assert property ($fell(pg_oe_reg) |->
        $past(eps_in_reg(i_lvl_psrc) && eps_in_reg(i_lvl_nsrc)))
        else $error("power good released with a rail below level");
    AST_PG_FAULT: assert property ((|i_rail_fault) |=> pg_oe_reg)
        else $error("power good released during a rail fault");
    AST_PG_ENABLE: assert property ((rail_en_reg != 4'hf) |=> pg_oe_reg)
        else $error("power good released with a rail disabled");
    AST_PG_ALL: assert property (!pg_oe_reg |-> $past(&rail_ok))
        else $error("power good released before all rails good");
    AST_CONV_REQ: assert property ($changed(req_tgl_reg) |-> $past(i_temp_req))
        else $error("conversion started without a request");
    AST_RESULT: assert property (done_ev |=>
        result_reg == $past(adc_data_reg))
        else $error("conversion result not stored");
    AST_COLD: assert property (done_ev && adc_data_reg < cold_thr_reg
        |=> flags_reg[FLG_COLD])
        else $error("cold event missed");
    AST_DISCHARGE: assert property (state_reg == ST_DISCHARGE &&
        state_next == ST_SLEEP |-> timer_reg == TMR_W'(DISCHARGE_CYCLES - 1))
        else $error("sleep entered before discharge delay");
    AST_NEG_ON: assert property (state_reg == ST_DISCHARGE |->
        neg_en_reg)
        else $error("negative boost off during discharge");
    AST_WAKE_UP: assert property (state_reg == ST_STANDBY && wake_s2_reg &&
        req_rise |=> state_reg == ST_UP_NEG ##1 neg_en_reg)
        else $error("request edge did not start power-up");
    AST_SLEEP_CFG: assert property (state_reg == ST_SLEEP |=>
        rail_cfg_reg == RAILS_RST && hot_thr_reg == HOT_RST)
        else $error("configuration kept in sleep");
    AST_UV: assert property (state_reg == ST_UP_NEG && tmo &&
        state_next == ST_STANDBY |=> flags_reg[FLG_UVN] ##1 !int_n_reg)
        else $error("boost timeout not flagged");

    COV_ACTIVE: cover property (state_reg == ST_UP_RAILS ##1 state_reg == ST_ACTIVE);
    COV_SLEEP: cover property (state_reg == ST_DISCHARGE ##1 state_reg == ST_SLEEP);
    COV_CONV: cover property (done_ev);
    COV_PG: cover property ($fell(pg_oe_reg));

endmodule
`default_nettype wire

/* File: test/eps_rail_model.sv */
/*
 * Far-side model of the supervisor: temperature converter, both boost
 * converters and the four rail level monitors.
 * Assumes it sees the supervisor's enables and its converter start.
 */
`timescale 1ns/10ps
`default_nettype none
module eps_rail_model
    import eps_pkg::*;
(
    input  wire logic                   i_clk_adc,
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_start,
    input  wire logic [TEMP_W-1:0]      i_code,
    input  wire logic                   i_neg_en,
    input  wire logic                   i_pos_en,
    input  wire logic [NRAIL-1:0]       i_rail_en,
    input  wire logic                   i_sag,
    input  wire logic                   i_hold,
    output logic                        o_done,
    output logic [TEMP_W-1:0]           o_data,
    output logic                        o_neg_good,
    output logic                        o_pos_good,
    output logic [NRAIL-1:0][LVL_W-1:0] o_lvl
);
    logic [1:0] wait_reg;

    initial begin
        {o_done, o_data, wait_reg, o_neg_good, o_pos_good} = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter answers only after a start; data churns outside done
    always @(posedge i_clk_adc) begin
        o_done <= (wait_reg == 2'h1);
        o_data <= (wait_reg == 2'h1) ? i_code : ~o_data;
        wait_reg <= i_start ? 2'h3 : wait_reg - {1'b0, wait_reg != 2'h0};
    end

    // Boosts report good one cycle after enable; the negative one not while held failing
    always @(posedge i_clk_sys) begin
        o_neg_good <= i_neg_en & ~i_hold;
        o_pos_good <= i_pos_en;
    end

    // Enabled rails sit exactly on the nine-tenths mark, others and a sagging rail 0 just under
    for (genvar r = 0; r < NRAIL; r++) begin : g_lvl
        assign o_lvl[r] = (i_rail_en[r] && !(r == 0 && i_sag)) ?
                          10'h384 : 10'h383;
    end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
/*
 * Self-checking bench for the display power supervisor.
 * Assumes the far-side model in eps_rail_model and short counts.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import eps_pkg::*;
;
    logic i_clk_sys = 1'b0, i_clk_adc = 1'b0, i_sys_rst = 1'b1;
    logic i_wake_request_pin = 1'b0, i_rail_sequence_request_pin = 1'b0;
    logic i_cfg_wr = 1'b0, i_cfg_active = 1'b0, i_temp_req = 1'b0;
    logic [3:0] i_cfg_rail_en = 4'h0, i_rail_fault = 4'h0;
    logic [2:0] i_cfg_ldo_vset = 3'h3;
    logic [7:0] i_cfg_hot_thr = 8'h8c, i_cfg_cool_thr = 8'h82;
    logic [7:0] i_cfg_cold_thr = 8'h64, i_cfg_delta_thr = 8'h08;
    logic [7:0] i_cfg_baseline = 8'h78, code = 8'h00, i_adc_data;
    logic [4:0] i_flag_clr = 5'h00, o_flags;
    logic [3:0][9:0] lvl;
    logic [3:0] o_rail_en;
    logic [2:0] o_ldo_vset;
    logic [7:0] o_temperature_result;
    logic sag = 1'b0, hold = 1'b0;
    logic i_neg_boost_good, i_pos_boost_good, i_adc_done;
    logic o_negative_boost_converter_en, o_positive_boost_en, o_sleep;
    logic o_rails_good_output_o, o_rails_good_output_oe, o_adc_start;
    logic o_interrupt_output_low_n, o_temp_busy;
    int errors = 0, comparisons = 0, n;

    // Clocks run unrelated in phase
    always #2.5 i_clk_sys = ~i_clk_sys;
    always #6 i_clk_adc = ~i_clk_adc;

    eps_power_supervisor #(.DISCHARGE_CYCLES(50), .BOOST_TMO_CYCLES(40)) dut (
        .i_lvl_pcp(lvl[0]), .i_lvl_ncp(lvl[1]), .i_lvl_psrc(lvl[2]),
        .i_lvl_nsrc(lvl[3]), .*);
    eps_rail_model far (.i_clk_adc(i_clk_adc), .i_clk_sys(i_clk_sys),
        .i_start(o_adc_start), .i_code(code), .i_sag(sag), .i_hold(hold),
        .i_neg_en(o_negative_boost_converter_en), .o_lvl(lvl),
        .i_pos_en(o_positive_boost_en), .i_rail_en(o_rail_en),
        .o_done(i_adc_done), .o_data(i_adc_data),
        .o_neg_good(i_neg_boost_good), .o_pos_good(i_pos_boost_good));

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait for a level; running out counts and ends the run
    task automatic wait_lvl(ref logic s, input logic want);
        for (n = 0; n < 3000 && s !== want; n++) @(posedge i_clk_sys);
        if (n == 3000) begin
            errors++;
            close_out();
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge i_clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Temperature codes and the flags each must leave behind
    logic [7:0] codes [3] = '{8'h90, 8'h60, 8'h8d};
    logic [4:0] flg [3] = '{5'h05, 5'h06, 5'h05};

    initial begin
        #400000;
        errors++;
        close_out();
    end

    initial begin
        tick(8);
        i_sys_rst <= 1'b0;
        tick(2);
        check("sleep", 8'h1, o_sleep);
        check("pg_oe", 8'h1, o_rails_good_output_oe);
        check("int_n", 8'h1, o_interrupt_output_low_n);
        check("result", 8'h00, o_temperature_result);
        check("vset", 8'h3, o_ldo_vset);
        check("pg_o", 8'h0, o_rails_good_output_o);
        $display("test reset done");
        i_wake_request_pin <= 1'b1;
        tick(6);
        i_cfg_wr <= 1'b1;
        i_cfg_rail_en <= 4'hf;
        i_cfg_ldo_vset <= 3'h5;
        tick(1);
        i_cfg_wr <= 1'b0;
        tick(2);
        check("vset", 8'h5, o_ldo_vset);
        i_rail_sequence_request_pin <= 1'b1;
        wait_lvl(o_rails_good_output_oe, 1'b0);
        check("rail_en", 8'hf, o_rail_en);
        sag <= 1'b1;
        tick(3);
        check("pg_sag", 8'h1, o_rails_good_output_oe);
        sag <= 1'b0;
        i_rail_fault <= 4'h4;
        tick(3);
        check("pg_fault", 8'h1, o_rails_good_output_oe);
        i_rail_fault <= 4'h0;
        wait_lvl(o_rails_good_output_oe, 1'b0);
        $display("test power-up done");
        // Clear flags between conversions so each result stands alone
        for (int k = 0; k < 3; k++) begin
            code <= codes[k];
            i_temp_req <= 1'b1;
            tick(1);
            i_temp_req <= 1'b0;
            tick(2);
            wait_lvl(o_temp_busy, 1'b0);
            tick(2);
            check("result", codes[k], o_temperature_result);
            check("flags", 8'(flg[k]), 8'(o_flags));
            check("int_n", 8'h0, o_interrupt_output_low_n);
            i_flag_clr <= 5'h1f;
            tick(1);
            i_flag_clr <= 5'h00;
            tick(2);
            check("cleared", 8'h00, 8'(o_flags));
        end
        $display("test temperature done");
        i_wake_request_pin <= 1'b0;
        wait_lvl(o_positive_boost_en, 1'b0);
        check("rail_off", 8'h0, o_rail_en);
        tick(40);
        check("neg_on", 8'h1, o_negative_boost_converter_en);
        check("early", 8'h0, o_sleep);
        wait_lvl(o_sleep, 1'b1);
        i_cfg_wr <= 1'b1;
        i_cfg_ldo_vset <= 3'h1;
        tick(1);
        i_cfg_wr <= 1'b0;
        tick(2);
        check("vset_sleep", 8'h3, o_ldo_vset);
        $display("test power-down done");
        // Request pin still high: wake goes straight to power-up
        hold <= 1'b1;
        i_wake_request_pin <= 1'b1;
        wait_lvl(o_negative_boost_converter_en, 1'b1);
        check("awake", 8'h0, o_sleep);
        wait_lvl(o_interrupt_output_low_n, 1'b0);
        check("uv_flag", 8'h08, 8'(o_flags));
        check("pos_off", 8'h0, o_positive_boost_en);
        $display("test boost timeout done");
        close_out();
    end
endmodule
`default_nettype wire
